// file: spisel_pkg.sv
package spisel_pkg;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFFSET   = 5'h00;
  localparam logic [4:0] DATA_OFFSET   = 5'h04;
  localparam logic [4:0] STATUS_OFFSET = 5'h08;
  localparam logic [4:0] CLKDIV_OFFSET = 5'h0C;

  // Control register fields
  localparam int CTRL_PORT_EN_BIT   = 0;
  localparam int CTRL_SEL_LO_BIT    = 2;
  localparam int CTRL_SEL_HI_BIT    = 3;
  localparam int CTRL_MASTER_EN_BIT = 6;

  // Status register fields
  localparam int STAT_DONE_BIT    = 7;
  localparam int STAT_WCOL_BIT    = 6;
  localparam int STAT_FAULT_BIT   = 5;
  localparam int STAT_OVRN_BIT    = 4;
  localparam int STAT_BUSY_BIT    = 3;
  localparam int STAT_ROUTED_BIT  = 2;
  localparam int STAT_TXFULL_BIT  = 1;
  localparam int STAT_RXFULL_BIT  = 0;

  // Values after reset
  localparam logic [1:0] SEL_MODE_RESET = 2'h1;
  localparam logic [7:0] CLKDIV_RESET   = 8'h04;

  localparam int BYTE_BITS = 8;

  localparam logic [1:0] BRESP_OKAY   = 2'h0;
  localparam logic [1:0] BRESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SPISEL_SEL_3WIRE  = 2'b00,
    SPISEL_SEL_4WIN   = 2'b01,
    SPISEL_SEL_OUT_LO = 2'b10,
    SPISEL_SEL_OUT_HI = 2'b11
  } spisel_sel_mode_t;

endpackage : spisel_pkg

// file: spisel_edge_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser with edge detection on the second stage
module spisel_edge_sync #(
  // Pin level at rest, so leaving reset shows no false edge
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Async level in
  input  wire logic async_in,
  // Synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } spisel_sync_state_t;

  spisel_sync_state_t state;
  spisel_sync_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.meta = async_in;
    next_state.sync = state.meta;
    next_state.prev = state.sync;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= '{meta: IDLE_LEVEL, sync: IDLE_LEVEL, prev: IDLE_LEVEL};
    end else begin
      state <= next_state;
    end
  end

  assign level = state.sync;
  assign rise  = state.sync & ~state.prev;
  assign fall  = ~state.sync & state.prev;

endmodule : spisel_edge_sync

// file: spisel_port.sv
`timescale 1ns/100ps
module spisel_port (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // AXI4-Lite write address
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial clock pin
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  // Master-out pin
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // Master-in pin
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // Select pin
  input  wire logic        slave_select_line_in,
  output logic             slave_select_line_out,
  output logic             slave_select_line_oe,
  output logic             slave_select_line_routed
);

  typedef struct packed {
    logic        rst_meta;
    logic        rst_sync;
    logic        awready;
    logic        wready;
    logic        have_aw;
    logic        have_w;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic        port_enable_bit;
    logic        master_enable_bit;
    logic [1:0]  select_mode_field;
    logic [7:0]  clkdiv;
    logic        transfer_done_flag;
    logic        wcol_flag;
    logic        mode_fault_flag;
    logic        overrun_flag;
    logic [7:0]  tx_buf;
    logic        tx_full;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic [7:0]  shreg;
    logic        sh_loaded;
    logic [2:0]  bit_cnt;
    logic        busy;
    logic        sample_bit;
    logic        frame_end;
    logic [7:0]  div_cnt;
    logic        sck_q;
    logic        mosi_q;
    logic        mosi_oe_q;
    logic        miso_q;
    logic        miso_oe_q;
    logic        sck_oe_q;
    logic        sel_q;
    logic        sel_oe_q;
    logic        routed_q;
    logic        mosi_m1;
    logic        mosi_s;
    logic        miso_m1;
    logic        miso_s;
  } spisel_state_t;

  spisel_state_t state;
  spisel_state_t next_state;

  logic sync_rst_b;
  logic sel_level;
  logic sel_fall;
  logic sck_level;
  logic sck_rise;
  logic sck_fall;

  assign sync_rst_b = state.rst_sync;

  // Select and serial clock synchronised before edges are seen
  spisel_edge_sync u_sel_sync (
    .core_clk (core_clk),
    .rst_b    (sync_rst_b),
    .async_in (slave_select_line_in),
    .level    (sel_level),
    .rise     (),
    .fall     (sel_fall)
  );

  spisel_edge_sync #(.IDLE_LEVEL(1'b0)) u_sck_sync (
    .core_clk (core_clk),
    .rst_b    (sync_rst_b),
    .async_in (sck_in),
    .level    (sck_level),
    .rise     (sck_rise),
    .fall     (sck_fall)
  );

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  always_comb begin
    logic        is_master;
    logic        is_slave;
    logic        selected;
    logic        shift_edge;
    logic        sample_edge;
    logic        byte_end;
    logic        div_tick;
    logic [31:0] ctrl_word;
    logic [31:0] stat_word;
    logic [31:0] wr_val;
    logic        wr_go;
    logic        tx_write;
    logic        data_read;
    logic        in_bit;
    is_master   = 1'b0;
    is_slave    = 1'b0;
    selected    = 1'b0;
    shift_edge  = 1'b0;
    sample_edge = 1'b0;
    byte_end    = 1'b0;
    div_tick    = 1'b0;
    wr_val      = '0;
    tx_write    = 1'b0;
    data_read   = 1'b0;
    in_bit      = 1'b0;
    next_state  = state;

    next_state.rst_meta = 1'b1;
    next_state.rst_sync = state.rst_meta;
    next_state.mosi_m1  = mosi_in;
    next_state.mosi_s   = state.mosi_m1;
    next_state.miso_m1  = miso_in;
    next_state.miso_s   = state.miso_m1;
    // Readies come up while the internal reset copy is still held low
    if (!state.rst_sync) begin
      next_state.awready = 1'b1;
      next_state.wready  = 1'b1;
      next_state.arready = 1'b1;
    end

    is_master = state.port_enable_bit & state.master_enable_bit;
    is_slave  = state.port_enable_bit & ~state.master_enable_bit;
    // Slave selection by mode
    unique case (state.select_mode_field)
      spisel_pkg::SPISEL_SEL_3WIRE: selected = 1'b1;
      spisel_pkg::SPISEL_SEL_4WIN:  selected = ~sel_level;
      default:                      selected = 1'b1;
    endcase

    ctrl_word = '0;
    ctrl_word[spisel_pkg::CTRL_PORT_EN_BIT]   = state.port_enable_bit;
    ctrl_word[spisel_pkg::CTRL_SEL_LO_BIT]    = state.select_mode_field[0];
    ctrl_word[spisel_pkg::CTRL_SEL_HI_BIT]    = state.select_mode_field[1];
    ctrl_word[spisel_pkg::CTRL_MASTER_EN_BIT] = state.master_enable_bit;
    stat_word = '0;
    stat_word[spisel_pkg::STAT_DONE_BIT]   = state.transfer_done_flag;
    stat_word[spisel_pkg::STAT_WCOL_BIT]   = state.wcol_flag;
    stat_word[spisel_pkg::STAT_FAULT_BIT]  = state.mode_fault_flag;
    stat_word[spisel_pkg::STAT_OVRN_BIT]   = state.overrun_flag;
    stat_word[spisel_pkg::STAT_BUSY_BIT]   = state.busy;
    stat_word[spisel_pkg::STAT_ROUTED_BIT] = state.routed_q;
    stat_word[spisel_pkg::STAT_TXFULL_BIT] = state.tx_full;
    stat_word[spisel_pkg::STAT_RXFULL_BIT] = state.rx_full;

    // Write channel: accept address and data in either order
    if (s_axi_awvalid && state.awready) begin
      next_state.have_aw = 1'b1;
      next_state.awaddr  = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.have_w = 1'b1;
      next_state.wdata  = s_axi_wdata;
      next_state.wstrb  = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    wr_go = state.have_aw & state.have_w & ~state.bvalid;
    if (wr_go) begin
      next_state.have_aw = 1'b0;
      next_state.have_w  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = spisel_pkg::BRESP_OKAY;
      unique case (state.awaddr)
        spisel_pkg::CTRL_OFFSET: begin
          wr_val = merge_bytes(ctrl_word, state.wdata, state.wstrb);
          next_state.port_enable_bit      = wr_val[spisel_pkg::CTRL_PORT_EN_BIT];
          next_state.select_mode_field[0] = wr_val[spisel_pkg::CTRL_SEL_LO_BIT];
          next_state.select_mode_field[1] = wr_val[spisel_pkg::CTRL_SEL_HI_BIT];
          next_state.master_enable_bit    = wr_val[spisel_pkg::CTRL_MASTER_EN_BIT];
        end
        spisel_pkg::DATA_OFFSET: begin
          tx_write = state.wstrb[0];
        end
        spisel_pkg::STATUS_OFFSET: begin
          // Write one to clear
          if (state.wstrb[0]) begin
            if (state.wdata[spisel_pkg::STAT_DONE_BIT])  next_state.transfer_done_flag = 1'b0;
            if (state.wdata[spisel_pkg::STAT_WCOL_BIT])  next_state.wcol_flag = 1'b0;
            if (state.wdata[spisel_pkg::STAT_FAULT_BIT]) next_state.mode_fault_flag = 1'b0;
            if (state.wdata[spisel_pkg::STAT_OVRN_BIT])  next_state.overrun_flag = 1'b0;
          end
        end
        spisel_pkg::CLKDIV_OFFSET: begin
          if (state.wstrb[0]) next_state.clkdiv = state.wdata[7:0];
        end
        default: next_state.bresp = spisel_pkg::BRESP_SLVERR;
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid  = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready  = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid  = 1'b1;
      unique case (s_axi_araddr)
        spisel_pkg::CTRL_OFFSET:   next_state.rdata = ctrl_word;
        spisel_pkg::DATA_OFFSET: begin
          next_state.rdata = {24'h00_0000, state.rx_buf};
          data_read        = 1'b1;
        end
        spisel_pkg::STATUS_OFFSET: next_state.rdata = stat_word;
        spisel_pkg::CLKDIV_OFFSET: next_state.rdata = {24'h00_0000, state.clkdiv};
        default:                   next_state.rdata = '0;
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end
    if (data_read) next_state.rx_full = 1'b0;

    // Transmit buffer, write collision when still full
    if (tx_write) begin
      if (state.tx_full) next_state.wcol_flag = 1'b1;
      else begin
        next_state.tx_buf  = state.wdata[7:0];
        next_state.tx_full = 1'b1;
      end
    end
    if (!state.sh_loaded && state.tx_full && !state.busy) begin
      next_state.shreg     = state.tx_buf;
      next_state.sh_loaded = 1'b1;
      next_state.tx_full   = 1'b0;
    end

    // Master clock divider and shifting
    if (is_master && (state.busy || state.sh_loaded)) begin
      next_state.busy = 1'b1;
      if (state.div_cnt >= state.clkdiv) begin
        next_state.div_cnt = '0;
        div_tick = 1'b1;
      end else begin
        next_state.div_cnt = state.div_cnt + 8'h01;
      end
      if (div_tick) begin
        next_state.sck_q = ~state.sck_q;
        if (!state.sck_q) sample_edge = 1'b1;
        else shift_edge = 1'b1;
      end
      in_bit = state.miso_s;
    end else if (is_slave && selected) begin
      // Slave uses the synchronised external clock
      sample_edge = sck_rise;
      shift_edge  = sck_fall;
      in_bit      = state.mosi_s;
    end
    if (!is_master) begin
      next_state.sck_q   = 1'b0;
      next_state.div_cnt = '0;
    end

    // Sample on the rising edge, move the shift register on the falling one
    if (sample_edge) begin
      next_state.sample_bit = in_bit;
      next_state.bit_cnt    = state.bit_cnt + 3'h1;
      next_state.busy       = 1'b1;
      if (state.bit_cnt == 3'(spisel_pkg::BYTE_BITS - 1)) byte_end = 1'b1;
    end
    if (byte_end) begin
      next_state.transfer_done_flag = 1'b1;
      next_state.frame_end          = 1'b1;
      if (state.rx_full && !data_read && is_slave) next_state.overrun_flag = 1'b1;
      else begin
        next_state.rx_buf  = {state.shreg[6:0], in_bit};
        next_state.rx_full = 1'b1;
      end
    end
    if (shift_edge) begin
      next_state.shreg = {state.shreg[6:0], state.sample_bit};
      // Frame ends at the falling edge after the last sample, clock low
      if (state.frame_end) begin
        next_state.frame_end = 1'b0;
        next_state.busy      = 1'b0;
        next_state.sh_loaded = 1'b0;
      end
    end

    // 4-wire slave counter reset
    if (is_slave && state.select_mode_field == spisel_pkg::SPISEL_SEL_4WIN && sel_fall) begin
      next_state.bit_cnt   = '0;
      next_state.busy      = 1'b0;
      next_state.frame_end = 1'b0;
    end

    // Multi-master mode fault
    if (is_master && state.select_mode_field == spisel_pkg::SPISEL_SEL_4WIN && sel_fall) begin
      next_state.master_enable_bit = 1'b0;
      next_state.port_enable_bit   = 1'b0;
      next_state.mode_fault_flag   = 1'b1;
    end

    if (!next_state.port_enable_bit) begin
      next_state.bit_cnt   = '0;
      next_state.frame_end = 1'b0;
      next_state.busy      = 1'b0;
      next_state.sh_loaded = 1'b0;
      next_state.sck_q     = 1'b0;
    end

    // Pin directions, all from flops
    next_state.sck_oe_q  = is_master;
    next_state.mosi_oe_q = is_master;
    next_state.mosi_q    = next_state.shreg[7];
    next_state.miso_oe_q = is_slave & selected;
    next_state.miso_q    = next_state.shreg[7];
    next_state.sel_oe_q  = state.select_mode_field[1];
    next_state.sel_q     = state.select_mode_field[1] ? state.select_mode_field[0] : 1'b1;
    next_state.routed_q  = state.select_mode_field != spisel_pkg::SPISEL_SEL_3WIRE;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state                   <= '0;
      state.select_mode_field <= spisel_pkg::SEL_MODE_RESET;
      state.clkdiv            <= spisel_pkg::CLKDIV_RESET;
      state.sel_q             <= 1'b1;
      state.routed_q          <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = spisel_pkg::BRESP_OKAY;
  assign sck_out       = state.sck_q;
  assign sck_oe        = state.sck_oe_q;
  assign mosi_out      = state.mosi_q;
  assign mosi_oe       = state.mosi_oe_q;
  assign miso_out      = state.miso_q;
  assign miso_oe       = state.miso_oe_q;
  assign slave_select_line_out    = state.sel_q;
  assign slave_select_line_oe     = state.sel_oe_q;
  assign slave_select_line_routed = state.routed_q;

endmodule : spisel_port

// file: spisel_port_properties.sv
`timescale 1ns/100ps
module spisel_port_checker (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Register bus answers
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // Serial pins
  input  wire logic        sck_out,
  input  wire logic        sck_oe,
  input  wire logic        mosi_out,
  input  wire logic        mosi_oe,
  input  wire logic        miso_oe,
  // Select pin
  input  wire logic        slave_select_line_in,
  input  wire logic        slave_select_line_out,
  input  wire logic        slave_select_line_oe,
  input  wire logic        slave_select_line_routed
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Select line working as an input
  sequence s_sel_in;
    slave_select_line_routed && !slave_select_line_oe;
  endsequence
  sequence s_sel_fall;
    $fell(slave_select_line_in);
  endsequence

  a_master_pins: assert property (mosi_oe |-> sck_oe)
    else $error("master-out driven without serial clock drive");
  a_miso_dir: assert property (miso_oe |-> !mosi_oe)
    else $error("master-in and master-out driven together");
  a_sck_source: assert property ($rose(sck_out) |-> sck_oe)
    else $error("serial clock rose while not driven");
  a_mosi_stable: assert property (mosi_oe && $rose(sck_out) |-> $stable(mosi_out))
    else $error("master-out changed at the sampling edge");
  a_sel_level: assert property (!slave_select_line_oe |-> slave_select_line_out)
    else $error("select output low while not driven");
  a_sel_routed: assert property (slave_select_line_oe |-> slave_select_line_routed)
    else $error("select driven while not routed");
  a_miso_unsel: assert property ((slave_select_line_routed && !slave_select_line_oe && !mosi_oe && slave_select_line_in) [*8] |-> !miso_oe)
    else $error("master-in driven by unselected slave");
  a_sel_sync: assert property (s_sel_in ##0 s_sel_fall ##0 (!mosi_oe && !miso_oe) |=> !miso_oe)
    else $error("select reached master-in without synchronising");
  a_fault_drop: assert property (s_sel_in ##0 s_sel_fall ##0 mosi_oe |-> ##[1:6] !mosi_oe)
    else $error("master kept driving after select fell");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before taken");
endmodule : spisel_port_checker

bind spisel_port spisel_port_checker u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .slave_select_line_in(slave_select_line_in), .slave_select_line_out(slave_select_line_out),
  .slave_select_line_oe(slave_select_line_oe),
  .slave_select_line_routed(slave_select_line_routed)
);

// file: spisel_far_model.sv
`timescale 1ns/100ps
module spisel_far_model (
  // Wire levels
  input  wire logic sck_w,
  input  wire logic mosi_w,
  input  wire logic miso_w,
  // Far side drive
  output logic      far_sck,
  output logic      far_mosi,
  output logic      far_miso
);
  logic [7:0] slv_tx;
  logic [7:0] slv_rx;
  initial begin
    far_sck = 1'h0;
    far_mosi = 1'h0;
    slv_tx = 8'h00;
    slv_rx = 8'h00;
  end
  // Sole slave on the bus, top bit first
  assign far_miso = slv_tx[7];
  always @(posedge sck_w) slv_rx <= {slv_rx[6:0], mosi_w};
  // Refill with changing bits so a stale level never passes
  always @(negedge sck_w) slv_tx <= {slv_tx[6:0], ~slv_tx[0]};
  task automatic load(input logic [7:0] b);
    slv_tx = b;
  endtask : load
  // Master role: clock stands low outside frames
  task automatic master_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      far_mosi = tx[i];
      #40;
      far_sck = 1'h1;
      rx[i] = miso_w;
      #40;
      far_sck = 1'h0;
    end
    far_mosi = ~far_mosi;
  endtask : master_byte
  task automatic stray(input int n);
    repeat (n) begin
      #40 far_sck = 1'h1;
      #40 far_sck = 1'h0;
    end
  endtask : stray
endmodule : spisel_far_model

// file: tb.sv
`timescale 1ns/100ps
module tb;
  localparam int LIMIT = 30000;
  logic        core_clk = 1'h0, rst_b = 1'h0, far_sel = 1'h1;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic   sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  wire logic   sel_out, sel_oe, routed, far_sck, far_mosi, far_miso;
  wire logic   sck_w = sck_oe ? sck_out : far_sck;
  wire logic   mosi_w = mosi_oe ? mosi_out : far_mosi;
  wire logic   miso_w = miso_oe ? miso_out : far_miso;
  wire logic   sel_w = sel_oe ? sel_out : far_sel;
  int          mismatches = 0, checks_done = 0, cycles = 0;

  spisel_port dut (
    .core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_in(sck_w),
    .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe),
    .slave_select_line_in(sel_w), .slave_select_line_out(sel_out),
    .slave_select_line_oe(sel_oe), .slave_select_line_routed(routed)
  );
  spisel_far_model far (
    .sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w),
    .far_sck(far_sck), .far_mosi(far_mosi), .far_miso(far_miso)
  );

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] b1(input logic v);
    return {31'h0000_0000, v};
  endfunction : b1

  // Ready and answers are taken at the rising edge that completes each channel
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    r = 2'h3;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d);
    d = 32'h0000_0000;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    s_axi_rready <= 1'h0;
  endtask : axi_read

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, spisel_pkg::BRESP_OKAY});
    repeat (3) @(posedge core_clk);
  endtask : wr

  task automatic done_then_data(input logic [7:0] exp);
    logic [31:0] d;
    d = 32'h0000_0000;
    while (d[spisel_pkg::STAT_DONE_BIT] !== 1'h1) axi_read(spisel_pkg::STATUS_OFFSET, d);
    axi_read(spisel_pkg::DATA_OFFSET, d);
    chk(d & 32'h0000_00FF, {24'h00_0000, exp});
    wr(spisel_pkg::STATUS_OFFSET, 32'h0000_00F0);
  endtask : done_then_data

  task automatic t_reset_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(spisel_pkg::CTRL_OFFSET, d);
    chk(d & 32'h0000_004D, 32'h0000_0004);
    axi_read(spisel_pkg::CLKDIV_OFFSET, d);
    chk(d & 32'h0000_00FF, {24'h00_0000, spisel_pkg::CLKDIV_RESET});
    axi_read(spisel_pkg::STATUS_OFFSET, d);
    chk(b1(d[spisel_pkg::STAT_ROUTED_BIT]), 32'h0000_0001);
    chk(b1(miso_oe), 32'h0000_0000);
    chk(b1(sel_oe), 32'h0000_0000);
    axi_read(5'h10, d);
    chk(d, 32'h0000_0000);
    chk({30'h0000_0000, s_axi_rresp}, {30'h0000_0000, spisel_pkg::BRESP_OKAY});
    axi_write(5'h14, 32'h0000_00FF, r);
    chk({30'h0000_0000, r}, {30'h0000_0000, spisel_pkg::BRESP_SLVERR});
  endtask : t_reset_regs

  task automatic t_master;
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0049);
    chk(b1(sel_oe), 32'h0000_0001);
    chk(b1(sel_out), 32'h0000_0000);
    chk(b1(mosi_oe), 32'h0000_0001);
    chk(b1(miso_oe), 32'h0000_0000);
    chk(b1(sck_oe), 32'h0000_0001);
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_004D);
    chk(b1(sel_out), 32'h0000_0001);
    far.load(8'h6A);
    wr(spisel_pkg::DATA_OFFSET, 32'h0000_001D);
    done_then_data(8'h6A);
    chk({24'h00_0000, far.slv_rx}, 32'h0000_001D);
  endtask : t_master

  task automatic t_fault;
    logic [31:0] d;
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0045);
    chk(b1(mosi_oe), 32'h0000_0001);
    far_sel <= 1'h0;
    repeat (10) @(posedge core_clk);
    chk(b1(mosi_oe), 32'h0000_0000);
    axi_read(spisel_pkg::STATUS_OFFSET, d);
    chk(b1(d[spisel_pkg::STAT_FAULT_BIT]), 32'h0000_0001);
    axi_read(spisel_pkg::CTRL_OFFSET, d);
    chk(d & 32'h0000_0041, 32'h0000_0000);
    far_sel <= 1'h1;
    wr(spisel_pkg::STATUS_OFFSET, 32'h0000_00F0);
  endtask : t_fault

  task automatic t_slave4;
    logic [31:0] d;
    logic [7:0]  rx;
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0000);
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0005);
    wr(spisel_pkg::DATA_OFFSET, 32'h0000_0096);
    chk(b1(miso_oe), 32'h0000_0000);
    far.stray(3);
    axi_read(spisel_pkg::STATUS_OFFSET, d);
    chk(b1(d[spisel_pkg::STAT_DONE_BIT]), 32'h0000_0000);
    far_sel <= 1'h0;
    repeat (4) @(posedge core_clk);
    chk(b1(miso_oe), 32'h0000_0001);
    far.master_byte(8'h5B, rx);
    chk({24'h00_0000, rx}, 32'h0000_0096);
    done_then_data(8'h5B);
    far_sel <= 1'h1;
  endtask : t_slave4

  task automatic t_slave3;
    logic [7:0] rx;
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0000);
    wr(spisel_pkg::CTRL_OFFSET, 32'h0000_0001);
    wr(spisel_pkg::DATA_OFFSET, 32'h0000_00C5);
    chk(b1(miso_oe), 32'h0000_0001);
    chk(b1(routed), 32'h0000_0000);
    far.master_byte(8'h8E, rx);
    chk({24'h00_0000, rx}, 32'h0000_00C5);
    done_then_data(8'h8E);
  endtask : t_slave3

  initial begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge core_clk);
    t_reset_regs();
    t_master();
    t_fault();
    t_slave4();
    t_slave3();
    end_sim();
  end
endmodule : tb
